// [fcpd_defs.vh]
`ifndef FCPD_DEFS_VH
`define FCPD_DEFS_VH

// ----------------------------------------
// Opcode field, low five bits of first byte
// ----------------------------------------
`define FCPD_OP_READ_TRACK 5'h02
`define FCPD_OP_SPECIFY 5'h03
`define FCPD_OP_SENSE_DRV 5'h04
`define FCPD_OP_WRITE 5'h05
`define FCPD_OP_READ 5'h06
`define FCPD_OP_RECAL 5'h07
`define FCPD_OP_SENSE_INT 5'h08
`define FCPD_OP_WRITE_DEL 5'h09
`define FCPD_OP_READ_ID 5'h0A
`define FCPD_OP_READ_DEL 5'h0C
`define FCPD_OP_FORMAT 5'h0D
`define FCPD_OP_DUMPREG 5'h0E
`define FCPD_OP_SEEK 5'h0F
`define FCPD_OP_VERSION 5'h10
`define FCPD_OP_SCAN_EQ 5'h11
`define FCPD_OP_PERP 5'h12
`define FCPD_OP_CONFIG 5'h13
`define FCPD_OP_LOCK 5'h14
`define FCPD_OP_VERIFY 5'h16
`define FCPD_OP_SCAN_LO 5'h19
`define FCPD_OP_SCAN_HI 5'h1D

// ----------------------------------------
// Command lengths in bytes, zero is invalid
// ----------------------------------------
`define FCPD_LEN_BAD 4'h0
`define FCPD_LEN_1 4'h1
`define FCPD_LEN_2 4'h2
`define FCPD_LEN_3 4'h3
`define FCPD_LEN_CFG 4'h4
`define FCPD_LEN_FMT 4'h6
`define FCPD_LEN_RW 4'h9
`define FCPD_BUF_LAST 9'h008

// ----------------------------------------
// Byte indices within a command
// ----------------------------------------
`define FCPD_IX_DRV 1
`define FCPD_IX_CYL 2
`define FCPD_IX_HEAD 3
`define FCPD_IX_SECT 4
`define FCPD_IX_N 5
`define FCPD_IX_EOT 6
`define FCPD_IX_GPL 7
`define FCPD_IX_DTL 8
`define FCPD_IX_FN 2
`define FCPD_IX_FSC 3
`define FCPD_IX_FGPL 4
`define FCPD_IX_FPAT 5
`define FCPD_IX_CFG 2

// ----------------------------------------
// Bit positions inside the first command byte and parameter bytes
// ----------------------------------------
`define FCPD_BIT_HEAD 2
`define FCPD_BIT_EC 7
`define FCPD_BIT_REL 7
`define FCPD_BIT_DIR 6
`define FCPD_BIT_EIS 6
`define FCPD_BIT_QUEUE_ENABLE_N 5
`define FCPD_BIT_OW 7
`define FCPD_PERP_MSB 5
`define FCPD_PERP_LSB 2
`define FCPD_THR_MSB 3

// ----------------------------------------
// Values and reset states
// ----------------------------------------
`define FCPD_ST0_INVALID 8'h80
`define FCPD_QUEUE_ENABLE_N_RST 1'b1
`define FCPD_EIS_RST 1'b0
`define FCPD_SECT_BASE 15'h0080
`define FCPD_N_MAX 8'h07

`endif

// [fcpd_len_calc.v]
`include "fcpd_defs.vh"

// ----------------------------------------
// Sector length arithmetic
// ----------------------------------------
module fcpd_len_calc (
    input wire [7:0] size_code,
    input wire [7:0] short_len,
    output wire [14:0] phys_len,
    output wire [14:0] xfer_len,
    output wire [14:0] fill_len
);

    // Codes above the largest allowed are held at the largest
    wire [7:0] n_lim;
    wire [14:0] short_ext;

    assign n_lim = (size_code > `FCPD_N_MAX) ? `FCPD_N_MAX : size_code;
    // Whole sector, also the CRC span
    assign phys_len = `FCPD_SECT_BASE << n_lim[2:0];
    assign short_ext = {7'h00, short_len};
    // Short length only counts for code zero
    assign xfer_len = (size_code == 8'h00 && short_ext < phys_len) ? short_ext : phys_len;
    // Bytes read and dropped, or written as zero
    assign fill_len = phys_len - xfer_len;

endmodule // fcpd_len_calc

// [fcpd_top.v]
`include "fcpd_defs.vh"

module fcpd_top (
    input wire core_clk,
    input wire rstn,
    input wire cmd_wr,
    input wire [7:0] cmd_byte,
    input wire res_rd,
    input wire exec_done,
    output reg host_request_flag_r,
    output reg transfer_direction_flag_r,
    output reg cmd_busy_r,
    output reg fdc_irq_r,
    output reg cmd_start_r,
    output reg [4:0] opcode_r,
    output reg [7:0] res_data_r,
    output reg [1:0] drive_pick_bits_r,
    output reg [3:0] drive_sel_r,
    output reg head_sel_r,
    output reg [7:0] cylinder_r,
    output reg [7:0] sector_num_r,
    output reg [7:0] size_code_r,
    output reg [7:0] final_sector_number_r,
    output reg [7:0] gap_length_r,
    output reg [7:0] short_sector_length_r,
    output reg [7:0] sectors_per_track_r,
    output reg [7:0] fill_pattern_r,
    output reg count_mode_flag_r,
    output reg relative_seek_r,
    output reg step_inward_r,
    output reg [3:0] perpendicular_drive_bits_r,
    output reg queue_enable_n_r,
    output reg implied_seek_enable_r,
    output reg [3:0] fifo_threshold_r,
    output reg seek_first_r,
    output reg [14:0] phys_len_r,
    output reg [14:0] xfer_len_r,
    output reg [14:0] fill_len_r
);

    // ----------------------------------------
    // Phases
    // ----------------------------------------
    localparam [1:0] S_CMD = 2'b00;
    localparam [1:0] S_BUSY = 2'b01;
    localparam [1:0] S_EXEC = 2'b10;
    localparam [1:0] S_RES = 2'b11;

    // ----------------------------------------
    // Opcode decoders
    // ----------------------------------------
    // Bytes needed per opcode, zero for invalid
    function [3:0] fcpd_cmd_len;
        input [4:0] op;
        begin
            case (op)
                `FCPD_OP_READ, `FCPD_OP_READ_DEL, `FCPD_OP_WRITE, `FCPD_OP_WRITE_DEL,
                `FCPD_OP_READ_TRACK, `FCPD_OP_VERIFY, `FCPD_OP_SCAN_EQ, `FCPD_OP_SCAN_LO,
                `FCPD_OP_SCAN_HI: fcpd_cmd_len = `FCPD_LEN_RW;
                `FCPD_OP_FORMAT: fcpd_cmd_len = `FCPD_LEN_FMT;
                `FCPD_OP_CONFIG: fcpd_cmd_len = `FCPD_LEN_CFG;
                `FCPD_OP_SPECIFY, `FCPD_OP_SEEK: fcpd_cmd_len = `FCPD_LEN_3;
                `FCPD_OP_RECAL, `FCPD_OP_SENSE_DRV, `FCPD_OP_READ_ID,
                `FCPD_OP_PERP: fcpd_cmd_len = `FCPD_LEN_2;
                `FCPD_OP_SENSE_INT, `FCPD_OP_VERSION, `FCPD_OP_DUMPREG,
                `FCPD_OP_LOCK: fcpd_cmd_len = `FCPD_LEN_1;
                default: fcpd_cmd_len = `FCPD_LEN_BAD;
            endcase
        end
    endfunction

    // Commands carrying a cylinder and sector block
    function fcpd_is_rw;
        input [4:0] op;
        begin
            fcpd_is_rw = (fcpd_cmd_len(op) == `FCPD_LEN_RW);
        end
    endfunction

    // ----------------------------------------
    // Command byte store
    // ----------------------------------------
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [3:0] idx_r;
    reg [3:0] idx_nxt;
    reg invalid_pend_r;
    reg [7:0] cmd_buf_r [0:8];
    wire wr_take;
    wire [4:0] op_w;
    wire [3:0] len_w;
    wire bad_w;
    wire fin_w;
    wire internal_w;
    wire [14:0] calc_phys;
    wire [14:0] calc_xfer;
    wire [14:0] calc_fill;

    // Writes outside the command phase are dropped
    assign wr_take = cmd_wr && (state_r == S_CMD);
    assign op_w = cmd_buf_r[0][4:0];
    assign len_w = fcpd_cmd_len(op_w);
    // First byte checked before any parameter is asked for
    assign bad_w = (state_r == S_BUSY) && (idx_r == 4'h0) && (len_w == `FCPD_LEN_BAD);
    assign fin_w = (state_r == S_BUSY) && !bad_w && (idx_r + 4'h1 == len_w);
    assign internal_w = (op_w == `FCPD_OP_SPECIFY) || (op_w == `FCPD_OP_CONFIG) || (op_w == `FCPD_OP_PERP);

    // One flop byte per position
    genvar g;
    generate
        for (g = 0; g <= `FCPD_BUF_LAST; g = g + 1) begin : g_buf
            localparam integer GI = g;
            always @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    cmd_buf_r[g] <= 8'h00;
                end else if (wr_take && idx_r == GI[3:0]) begin
                    cmd_buf_r[g] <= cmd_byte;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Phase sequencing
    // ----------------------------------------
    // Next phase and byte index
    always @* begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        case (state_r)
            S_CMD: begin
                if (wr_take) begin
                    state_nxt = S_BUSY;
                end
            end
            S_BUSY: begin
                if (bad_w) begin
                    state_nxt = S_CMD;
                    idx_nxt = 4'h0;
                end else if (fin_w) begin
                    idx_nxt = 4'h0;
                    if (op_w == `FCPD_OP_SENSE_INT) begin
                        state_nxt = S_RES;
                    end else if (internal_w) begin
                        state_nxt = S_CMD;
                    end else begin
                        state_nxt = S_EXEC;
                    end
                end else begin
                    state_nxt = S_CMD;
                    idx_nxt = idx_r + 4'h1;
                end
            end
            S_EXEC: begin
                if (exec_done) begin
                    state_nxt = S_CMD;
                end
            end
            S_RES: begin
                if (res_rd) begin
                    state_nxt = S_CMD;
                end
            end
            default: begin
                state_nxt = S_CMD;
                idx_nxt = 4'h0;
            end
        endcase
    end

    // Phase registers, handshake flags, interrupt and result
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= S_CMD;
            idx_r <= 4'h0;
            host_request_flag_r <= 1'b1;
            transfer_direction_flag_r <= 1'b0;
            cmd_busy_r <= 1'b0;
            fdc_irq_r <= 1'b0;
            invalid_pend_r <= 1'b0;
            cmd_start_r <= 1'b0;
            res_data_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            // Ready for a write: request 1, direction 0
            host_request_flag_r <= (state_nxt == S_CMD) || (state_nxt == S_RES);
            transfer_direction_flag_r <= (state_nxt == S_RES);
            cmd_busy_r <= (state_nxt != S_CMD) || (idx_nxt != 4'h0);
            cmd_start_r <= fin_w && !internal_w && (op_w != `FCPD_OP_SENSE_INT);
            if (bad_w) begin
                fdc_irq_r <= 1'b1;
                invalid_pend_r <= 1'b1;
            end else if (fin_w && op_w == `FCPD_OP_SENSE_INT) begin
                // No other interrupt source here, so status is always invalid
                res_data_r <= `FCPD_ST0_INVALID;
                fdc_irq_r <= 1'b0;
                invalid_pend_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Length arithmetic
    // ----------------------------------------
    fcpd_len_calc u_len (
        .size_code(cmd_buf_r[`FCPD_IX_N]),
        .short_len(cmd_buf_r[`FCPD_IX_DTL]),
        .phys_len(calc_phys),
        .xfer_len(calc_xfer),
        .fill_len(calc_fill)
    );

    // ----------------------------------------
    // Parameter latch
    // ----------------------------------------
    // All fields change only on the last byte of a command
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            opcode_r <= 5'h00;
            drive_pick_bits_r <= 2'b00;
            drive_sel_r <= 4'h1;
            head_sel_r <= 1'b0;
            cylinder_r <= 8'h00;
            sector_num_r <= 8'h00;
            size_code_r <= 8'h00;
            final_sector_number_r <= 8'h00;
            gap_length_r <= 8'h00;
            short_sector_length_r <= 8'h00;
            sectors_per_track_r <= 8'h00;
            fill_pattern_r <= 8'h00;
            count_mode_flag_r <= 1'b0;
            relative_seek_r <= 1'b0;
            step_inward_r <= 1'b0;
            perpendicular_drive_bits_r <= 4'h0;
            queue_enable_n_r <= `FCPD_QUEUE_ENABLE_N_RST;
            implied_seek_enable_r <= `FCPD_EIS_RST;
            fifo_threshold_r <= 4'h0;
            seek_first_r <= 1'b0;
            phys_len_r <= 15'h0000;
            xfer_len_r <= 15'h0000;
            fill_len_r <= 15'h0000;
        end else if (fin_w) begin
            opcode_r <= op_w;
            if (len_w >= `FCPD_LEN_2 && !internal_w) begin
                // High pick bit is the most significant
                drive_pick_bits_r <= cmd_buf_r[`FCPD_IX_DRV][1:0];
                drive_sel_r <= 4'h1 << cmd_buf_r[`FCPD_IX_DRV][1:0];
                head_sel_r <= cmd_buf_r[`FCPD_IX_DRV][`FCPD_BIT_HEAD];
            end
            if (fcpd_is_rw(op_w)) begin
                cylinder_r <= cmd_buf_r[`FCPD_IX_CYL];
                sector_num_r <= cmd_buf_r[`FCPD_IX_SECT];
                size_code_r <= cmd_buf_r[`FCPD_IX_N];
                final_sector_number_r <= cmd_buf_r[`FCPD_IX_EOT];
                gap_length_r <= cmd_buf_r[`FCPD_IX_GPL];
                phys_len_r <= calc_phys;
                xfer_len_r <= calc_xfer;
                fill_len_r <= calc_fill;
                // Seek ahead of the transfer only when enabled
                seek_first_r <= implied_seek_enable_r;
                if (op_w == `FCPD_OP_VERIFY) begin
                    count_mode_flag_r <= cmd_buf_r[`FCPD_IX_DRV][`FCPD_BIT_EC];
                end else begin
                    count_mode_flag_r <= 1'b0;
                end
                if (op_w == `FCPD_OP_VERIFY && cmd_buf_r[`FCPD_IX_DRV][`FCPD_BIT_EC]) begin
                    sectors_per_track_r <= cmd_buf_r[`FCPD_IX_DTL];
                end else begin
                    short_sector_length_r <= cmd_buf_r[`FCPD_IX_DTL];
                end
            end
            case (op_w)
                `FCPD_OP_FORMAT: begin
                    size_code_r <= cmd_buf_r[`FCPD_IX_FN];
                    sectors_per_track_r <= cmd_buf_r[`FCPD_IX_FSC];
                    gap_length_r <= cmd_buf_r[`FCPD_IX_FGPL];
                    fill_pattern_r <= cmd_buf_r[`FCPD_IX_FPAT];
                    seek_first_r <= 1'b0;
                end
                `FCPD_OP_SEEK: begin
                    cylinder_r <= cmd_buf_r[`FCPD_IX_CYL];
                    relative_seek_r <= cmd_buf_r[0][`FCPD_BIT_REL];
                    // 0 steps out, 1 steps toward the spindle
                    step_inward_r <= cmd_buf_r[0][`FCPD_BIT_DIR];
                    seek_first_r <= 1'b0;
                end
                `FCPD_OP_CONFIG: begin
                    implied_seek_enable_r <= cmd_buf_r[`FCPD_IX_CFG][`FCPD_BIT_EIS];
                    queue_enable_n_r <= cmd_buf_r[`FCPD_IX_CFG][`FCPD_BIT_QUEUE_ENABLE_N];
                    fifo_threshold_r <= cmd_buf_r[`FCPD_IX_CFG][`FCPD_THR_MSB:0];
                end
                `FCPD_OP_PERP: begin
                    // Drive bits change only with the overwrite bit set
                    if (cmd_buf_r[`FCPD_IX_DRV][`FCPD_BIT_OW]) begin
                        perpendicular_drive_bits_r <=
                            cmd_buf_r[`FCPD_IX_DRV][`FCPD_PERP_MSB:`FCPD_PERP_LSB];
                    end
                end
                default: begin
                    relative_seek_r <= relative_seek_r;
                end
            endcase
        end
    end

endmodule // fcpd_top

// [fcpd_host_model.sv]
// ----------------------------------------
// Host side model: writes command bytes and reads results
// ----------------------------------------
module fcpd_host_model (
    input wire core_clk,
    input wire host_request_flag_r,
    input wire transfer_direction_flag_r,
    output logic cmd_wr,
    output logic [7:0] cmd_byte,
    output logic res_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle values at time zero
    initial begin
        cmd_wr = 1'b0;
        cmd_byte = 8'h00;
        res_rd = 1'b0;
    end

    // Poll the status flags, bounded, sampled after each edge has settled
    task automatic wait_flag(input logic want_dir);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        while (!(host_request_flag_r === 1'b1 && transfer_direction_flag_r === want_dir) && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask

    // One-cycle write; data line shows inverse once released
    task automatic put(input logic [7:0] b);
        @(posedge core_clk);
        cmd_wr <= 1'b1;
        cmd_byte <= b;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        cmd_byte <= ~b;
    endtask

    // Write only while the controller requests a host-to-controller byte
    task automatic send(input logic [7:0] b);
        wait_flag(1'b0);
        put(b);
    endtask

    // Read one result byte once direction points to the host
    task automatic fetch();
        wait_flag(1'b1);
        @(posedge core_clk);
        res_rd <= 1'b1;
        @(posedge core_clk);
        res_rd <= 1'b0;
    endtask
endmodule // fcpd_host_model

// [fcpd_top_sva.sv]
`include "fcpd_defs.vh"

// ----------------------------------------
// Port-level checks of the command decoder
// ----------------------------------------
module fcpd_top_sva (
    input wire core_clk,
    input wire rstn,
    input wire cmd_wr,
    input wire [7:0] cmd_byte,
    input wire host_request_flag_r,
    input wire transfer_direction_flag_r,
    input wire cmd_busy_r,
    input wire fdc_irq_r,
    input wire cmd_start_r,
    input wire [4:0] opcode_r,
    input wire [7:0] res_data_r,
    input wire [1:0] drive_pick_bits_r,
    input wire [3:0] drive_sel_r,
    input wire [7:0] cylinder_r,
    input wire [7:0] size_code_r,
    input wire [7:0] final_sector_number_r,
    input wire [7:0] short_sector_length_r,
    input wire implied_seek_enable_r,
    input wire seek_first_r,
    input wire [14:0] phys_len_r,
    input wire [14:0] xfer_len_r,
    input wire [14:0] fill_len_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Start of a plain read or write transfer
    wire rw_start = cmd_start_r && (opcode_r == `FCPD_OP_READ || opcode_r == `FCPD_OP_WRITE);

    byte_take_a: assert property (
        cmd_wr && host_request_flag_r && !transfer_direction_flag_r |-> ##[1:2] !host_request_flag_r)
        else $error("accepted byte did not drop the request flag");
    bad_opcode_a: assert property (
        cmd_wr && host_request_flag_r && !transfer_direction_flag_r && !cmd_busy_r && cmd_byte[4:0] == 5'h1F
        |-> ##[2:3] fdc_irq_r) else $error("invalid opcode raised no interrupt");
    sense_status_a: assert property (
        $rose(transfer_direction_flag_r) && opcode_r == `FCPD_OP_SENSE_INT
        |-> res_data_r == `FCPD_ST0_INVALID && !fdc_irq_r) else $error("sense status wrong");
    drive_decode_a: assert property (
        drive_sel_r == (4'h1 << drive_pick_bits_r)) else $error("drive select does not match pick bits");
    len_short_a: assert property (
        rw_start && size_code_r == 8'h00 |-> phys_len_r == 15'h0080
        && xfer_len_r == ((short_sector_length_r > 8'h80) ? 15'h0080 : {7'h00, short_sector_length_r}))
        else $error("short sector lengths wrong");
    len_full_a: assert property (
        rw_start && size_code_r != 8'h00 && size_code_r <= 8'h07
        |-> phys_len_r == (15'h0080 << size_code_r[2:0]) && xfer_len_r == phys_len_r)
        else $error("full sector lengths wrong");
    zero_fill_a: assert property (
        rw_start |-> fill_len_r == phys_len_r - xfer_len_r) else $error("fill length wrong");
    seek_first_a: assert property (
        rw_start |-> seek_first_r == implied_seek_enable_r) else $error("implied seek flag wrong");
    field_hold_a: assert property (
        cmd_busy_r && !cmd_start_r && !host_request_flag_r
        |-> $stable(cylinder_r) && $stable(final_sector_number_r)) else $error("fields moved while busy");
endmodule // fcpd_top_sva

bind fcpd_top fcpd_top_sva fcpd_top_sva_i (.core_clk(core_clk), .rstn(rstn), .cmd_wr(cmd_wr),
    .cmd_byte(cmd_byte), .host_request_flag_r(host_request_flag_r),
    .transfer_direction_flag_r(transfer_direction_flag_r), .cmd_busy_r(cmd_busy_r), .fdc_irq_r(fdc_irq_r),
    .cmd_start_r(cmd_start_r), .opcode_r(opcode_r), .res_data_r(res_data_r),
    .drive_pick_bits_r(drive_pick_bits_r), .drive_sel_r(drive_sel_r), .cylinder_r(cylinder_r),
    .size_code_r(size_code_r), .final_sector_number_r(final_sector_number_r),
    .short_sector_length_r(short_sector_length_r), .implied_seek_enable_r(implied_seek_enable_r),
    .seek_first_r(seek_first_r), .phys_len_r(phys_len_r), .xfer_len_r(xfer_len_r), .fill_len_r(fill_len_r));

// [testbench.sv]
// ----------------------------------------
// Self-checking bench for the command decoder
// ----------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic exec_done = 1'b0;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    wire cmd_wr, res_rd, host_request_flag, dir, busy, irq, cstart, head, ecf, rel, stin, qen, implied_seek_enable, sfirst;
    wire [7:0] cmd_byte, res_data, cyl, sect, size, final_sector_number, gap, short_sector_length, spt, pat;
    wire [4:0] opc;
    wire [1:0] pick;
    wire [3:0] dsel, perp, thr;
    wire [14:0] plen, xlen, flen;

    // 250 MHz clock, reset held 16 cycles
    always #2 core_clk = ~core_clk;
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
    end

    fcpd_top fcpd_top_i (.core_clk(core_clk), .rstn(rstn), .cmd_wr(cmd_wr), .cmd_byte(cmd_byte),
        .res_rd(res_rd), .exec_done(exec_done), .host_request_flag_r(host_request_flag), .transfer_direction_flag_r(dir),
        .cmd_busy_r(busy), .fdc_irq_r(irq), .cmd_start_r(cstart), .opcode_r(opc), .res_data_r(res_data),
        .drive_pick_bits_r(pick), .drive_sel_r(dsel), .head_sel_r(head), .cylinder_r(cyl),
        .sector_num_r(sect), .size_code_r(size), .final_sector_number_r(final_sector_number), .gap_length_r(gap),
        .short_sector_length_r(short_sector_length), .sectors_per_track_r(spt), .fill_pattern_r(pat),
        .count_mode_flag_r(ecf), .relative_seek_r(rel), .step_inward_r(stin),
        .perpendicular_drive_bits_r(perp), .queue_enable_n_r(qen), .implied_seek_enable_r(implied_seek_enable),
        .fifo_threshold_r(thr), .seek_first_r(sfirst), .phys_len_r(plen), .xfer_len_r(xlen), .fill_len_r(flen));
    fcpd_host_model host_i (.core_clk(core_clk), .host_request_flag_r(host_request_flag), .transfer_direction_flag_r(dir),
        .cmd_wr(cmd_wr), .cmd_byte(cmd_byte), .res_rd(res_rd));

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // Send len bytes, first byte in the top bits
    task automatic cmd(input int len, input logic [71:0] v);
        for (int i = 0; i < len; i++) host_i.send(v[8*(len-1-i)+:8]);
    endtask

    task automatic idle();
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        while (!(busy === 1'b0 && host_request_flag === 1'b1) && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("idle", busy, 1'b0);
    endtask

    // Catch the one-cycle start pulse
    task automatic wait_start();
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        while (cstart !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("cmd_start", cstart, 1'b1);
    endtask

    task automatic end_exec();
        @(posedge core_clk);
        exec_done <= 1'b1;
        @(posedge core_clk);
        exec_done <= 1'b0;
        idle();
    endtask

    task automatic t_reset();
        @(posedge core_clk);
        #1;
        chk("queue_n", qen, 1'b1);
        chk("eis", implied_seek_enable, 1'b0);
        chk("dsel", dsel, 4'h1);
        chk("rqm", host_request_flag, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_invalid();
        cmd(1, 8'h1F);
        idle();
        chk("irq", irq, 1'b1);
        cmd(1, 8'h08);
        host_i.wait_flag(1'b1);
        chk("dir", dir, 1'b1);
        chk("st0", res_data, 8'h80);
        chk("irq_clr", irq, 1'b0);
        host_i.fetch();
        idle();
        $display("test invalid done");
    endtask

    // Read/write/verify decode, a refused write mid-execution, then hold
    task automatic t_rw(input logic [7:0] op, drv, n, sl, input logic [14:0] ph, xf, input logic sk);
        cmd(9, {op, drv, 8'hFF, 8'h00, 8'h01, n, 8'h12, 8'h1B, sl});
        wait_start();
        chk("cyl", cyl, 8'hFF);
        chk("eot", final_sector_number, 8'h12);
        chk("pick", pick, drv[1:0]);
        chk("dsel", dsel, 4'h1 << drv[1:0]);
        chk("phys", plen, ph);
        chk("xfer", xlen, xf);
        chk("fill", flen, ph - xf);
        chk("seek_first", sfirst, sk);
        chk("opcode", opc, op[4:0]);
        chk("head", head, drv[2]);
        chk("sector", sect, 8'h01);
        chk("size", size, n);
        chk("gap", gap, 8'h1B);
        chk("count_mode", ecf, drv[7]);
        if (drv[7]) chk("spt", spt, sl);
        else chk("dtl", short_sector_length, sl);
        host_i.put(8'h55);
        end_exec();
        chk("cyl_hold", cyl, 8'hFF);
        chk("eot_hold", final_sector_number, 8'h12);
        $display("test rw %h done", op);
    endtask

    task automatic t_seek_perp_fmt();
        for (int d = 0; d < 2; d++) begin
            cmd(3, {(d == 1) ? 8'hCF : 8'h8F, 8'h03, 8'h10});
            wait_start();
            chk("rel", rel, 1'b1);
            chk("inward", stin, d[0]);
            chk("seek_cyl", cyl, 8'h10);
            chk("seek_nofirst", sfirst, 1'b0);
            end_exec();
        end
        cmd(2, 16'h12A8);
        idle();
        chk("perp", perp, 4'hA);
        cmd(6, 48'h0D02030B2AE5);
        wait_start();
        chk("pattern", pat, 8'hE5);
        chk("fmt_spt", spt, 8'h0B);
        chk("fmt_size", size, 8'h03);
        chk("fmt_gap", gap, 8'h2A);
        chk("fmt_pick", pick, 2'h2);
        end_exec();
        $display("test seek perp format done");
    endtask

    // Main sequence
    initial begin
        @(posedge rstn);
        t_reset();
        t_invalid();
        t_rw(8'h46, 8'h06, 8'h00, 8'h40, 15'h0080, 15'h0040, 1'b0);
        cmd(4, 32'h13004500);
        idle();
        chk("queue_n", qen, 1'b0);
        chk("eis", implied_seek_enable, 1'b1);
        chk("thr", thr, 4'h5);
        $display("test config done");
        t_rw(8'h45, 8'h01, 8'h03, 8'hFF, 15'h0400, 15'h0400, 1'b1);
        t_rw(8'hD6, 8'h83, 8'h02, 8'h09, 15'h0200, 15'h0200, 1'b1);
        t_seek_perp_fmt();
        conclude();
    end
endmodule // testbench
